/* hdl/fsgc_defs.svh */
// Register offsets, field positions and reset values of the sync generator
`ifndef FSGC_DEFS_SVH
`define FSGC_DEFS_SVH
// ------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------
`define FSGC_ADDR_CTRL 8'h18
`define FSGC_ADDR_HIGH_HI 8'h19
`define FSGC_ADDR_HIGH_LO 8'h1a
`define FSGC_ADDR_LOW_HI 8'h1b
`define FSGC_ADDR_LOW_LO 8'h1c
`define FSGC_ADDR_STATUS 8'h20
// ------------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------------
`define FSGC_BIT_ENABLE 0
`define FSGC_BIT_STYLE 1
`define FSGC_BIT_INIT 2
`define FSGC_BIT_ONESHOT 3
`define FSGC_MODE_MSB 7
`define FSGC_MODE_LSB 4
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define FSGC_RST_CTRL 8'h00
`define FSGC_RST_TIME 8'h00
`endif

/* hdl/fsgc_pkg.sv */
// Types shared by the sync generator
package fsgc_pkg;
    // Generator phase states, Gray coded along idle->high/low path
    typedef enum logic [1:0]
    {
        FSGC_IDLE = 2'b00,
        FSGC_HIGH = 2'b01,
        FSGC_LOW = 2'b11
    } fsgc_state_t;
    // APB request bundle
    typedef struct packed
    {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fsgc_apb_req_t;
    // Decoded source selection
    typedef struct packed
    {
        logic external;
        logic use_ref;
        logic [2:0] index;
    } fsgc_src_t;
endpackage : fsgc_pkg

/* hdl/fsgc_top.sv */
// Camera sync pulse generator with APB control registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "fsgc_defs.svh"

// Overview of operation
// (R1) Modes 0000-0011 time from port frame clock
// (R2) Mode 01xx times from 25MHz reference
// (R3) Modes 1xxx pass external pin 0-7
// (R4) Writing one-shot bit emits one pulse
// (R5) One-shot bit self-clears, reads zero
// (R6) Software waits pulse length before next shot
// (R7) Software keeps enable low during one-shots
// (R8) Initial-level bit sets output start level
// (R9) Style zero: separate 16-bit high/low lengths
// (R10) Style one: 24-bit length for both phases
// (R11) Phase lasts programmed value plus one
// (R12) Lengths split into upper and lower bytes
// (R13) Periodic waveform only while enable set
// (R14) New source and style taken at phase start; lengths act at once
module fsgc_top
    import fsgc_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int PINS = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PORTS-1:0] port_frame_tick,
    input wire logic ref_tick,
    input wire logic [PINS-1:0] ext_sync_pin,
    output logic camera_sync_pulse
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    fsgc_apb_req_t req; // Bundled bus request
    logic [7:0] ctrl_q; // Control word, one-shot bit always held zero
    logic [7:0] high_hi_q; // High length upper byte
    logic [7:0] high_lo_q; // High length lower byte
    logic [7:0] low_hi_q; // Low length upper byte
    logic [7:0] low_lo_q; // Low length lower byte
    logic wr_stb; // Write taken this edge
    logic oneshot_d; // One-shot request pulse

    assign req = '{sel: psel, enable: penable, write: pwrite,
                   addr: paddr, wdata: pwdata};
    assign wr_stb = req.sel && req.enable && req.write && pready;

    // Is the address one of ours
    function automatic logic fsgc_mapped(input logic [7:0] a);
        fsgc_mapped = (a == `FSGC_ADDR_CTRL) || (a == `FSGC_ADDR_HIGH_HI)
            || (a == `FSGC_ADDR_HIGH_LO) || (a == `FSGC_ADDR_LOW_HI)
            || (a == `FSGC_ADDR_LOW_LO) || (a == `FSGC_ADDR_STATUS);
    endfunction : fsgc_mapped

    // Slave answers one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            // Pulse ready for exactly one access cycle
            pready <= req.sel && req.enable && !pready;
            pslverr <= req.sel && req.enable && !pready
                && !fsgc_mapped(req.addr);
        end
    end

    // Control register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `FSGC_RST_CTRL;
        else if (wr_stb && req.addr == `FSGC_ADDR_CTRL)
        begin
            ctrl_q <= req.wdata[7:0];
            // (R5) bit never stored
            ctrl_q[`FSGC_BIT_ONESHOT] <= 1'b0;
        end
    end

    // (R12) byte halves of lengths
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_hi_q <= `FSGC_RST_TIME;
            high_lo_q <= `FSGC_RST_TIME;
            low_hi_q <= `FSGC_RST_TIME;
            low_lo_q <= `FSGC_RST_TIME;
        end
        else if (wr_stb)
        begin
            if (req.addr == `FSGC_ADDR_HIGH_HI)
                high_hi_q <= req.wdata[7:0];
            if (req.addr == `FSGC_ADDR_HIGH_LO)
                high_lo_q <= req.wdata[7:0];
            if (req.addr == `FSGC_ADDR_LOW_HI)
                low_hi_q <= req.wdata[7:0];
            if (req.addr == `FSGC_ADDR_LOW_LO)
                low_lo_q <= req.wdata[7:0];
        end
    end

    // (R4) writing one requests a shot, zero ignored
    assign oneshot_d = wr_stb && req.addr == `FSGC_ADDR_CTRL
        && req.wdata[`FSGC_BIT_ONESHOT];

    // ------------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------------
    fsgc_src_t src_act_q; // Source latched at phase start
    logic style_act_q; // Period style latched at phase start
    fsgc_src_t src_new; // Source as now programmed
    logic [7:0] ctrl_now; // Control as it stands after this edge's write
    logic tick; // Timing tick from the active source

    // Mode field to source selection
    function automatic fsgc_src_t fsgc_decode(input logic [3:0] m);
        fsgc_src_t s;
        s.external = m[3];
        s.use_ref = !m[3] && m[2];
        s.index = m[2:0];
        fsgc_decode = s;
    endfunction : fsgc_decode

    // A shot written with a new mode must run on that mode, not the old one
    assign ctrl_now = (wr_stb && req.addr == `FSGC_ADDR_CTRL)
        ? req.wdata[7:0] : ctrl_q;
    assign src_new = fsgc_decode(ctrl_now[`FSGC_MODE_MSB:`FSGC_MODE_LSB]);

    // Select tick for internal timing
    always_comb
    begin
        // (R2) reference clock ignores low mode bits
        if (src_act_q.use_ref)
            tick = ref_tick;
        // (R1) back-channel frame clock of chosen port
        else if (!src_act_q.external)
            tick = port_frame_tick[src_act_q.index[1:0]];
        else
            tick = 1'b0;
    end

    // ------------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------------
    fsgc_state_t state_q; // Generator phase
    logic [23:0] count_q; // Ticks counted so far in current phase
    logic level_d; // Next output level
    logic shot_q; // A one-shot is running
    logic [23:0] len_high; // High phase length minus one
    logic [23:0] len_low; // Low phase length minus one
    logic run; // Generator should be running

    // (R9) (R10) phase lengths per style
    always_comb
    begin
        if (style_act_q)
        begin
            len_high = {high_lo_q, low_hi_q, low_lo_q};
            len_low = {high_lo_q, low_hi_q, low_lo_q};
        end
        else
        begin
            len_high = {8'h00, high_hi_q, high_lo_q};
            len_low = {8'h00, low_hi_q, low_lo_q};
        end
    end

    // (R13) periodic output only when enabled
    assign run = ctrl_q[`FSGC_BIT_ENABLE];

    // Phase sequencer; one-shot makes a single high phase.
    // A shot during periodic running is ignored since the
    // two would fight over the same counter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= FSGC_IDLE;
            count_q <= 24'h000000;
            shot_q <= 1'b0;
            src_act_q <= '0;
            style_act_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                FSGC_IDLE:
                begin
                    // (R14) settings follow freely while idle
                    src_act_q <= src_new;
                    style_act_q <= ctrl_now[`FSGC_BIT_STYLE];
                    count_q <= 24'h000000;
                    if (!src_new.external && (run || oneshot_d))
                    begin
                        state_q <= FSGC_HIGH;
                        shot_q <= !run;
                    end
                end
                FSGC_HIGH:
                begin
                    // (R11) value plus one ticks per phase
                    if (tick)
                    begin
                        if (count_q >= len_high)
                        begin
                            count_q <= 24'h000000;
                            // (R14) reload settings at phase start
                            src_act_q <= src_new;
                            style_act_q <= ctrl_now[`FSGC_BIT_STYLE];
                            // (R4) one-shot ends after high phase
                            if (shot_q || !run || src_new.external)
                            begin
                                state_q <= FSGC_IDLE;
                                shot_q <= 1'b0;
                            end
                            else
                                state_q <= FSGC_LOW;
                        end
                        else
                            count_q <= count_q + 24'h000001;
                    end
                end
                FSGC_LOW:
                begin
                    if (tick)
                    begin
                        if (count_q >= len_low)
                        begin
                            count_q <= 24'h000000;
                            src_act_q <= src_new;
                            style_act_q <= ctrl_now[`FSGC_BIT_STYLE];
                            // (R13) stop at a phase boundary only
                            if (!run || src_new.external)
                                state_q <= FSGC_IDLE;
                            else
                                state_q <= FSGC_HIGH;
                        end
                        else
                            count_q <= count_q + 24'h000001;
                    end
                end
                default:
                    state_q <= FSGC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------------
    // Pulse is the inverse of the initial level while high phase runs
    always_comb
    begin
        if (src_act_q.external && state_q == FSGC_IDLE)
            // (R3) pass the chosen external pin
            level_d = ext_sync_pin[src_act_q.index];
        else if (state_q == FSGC_HIGH)
            // (R8) active phase inverts starting level
            level_d = !ctrl_q[`FSGC_BIT_INIT];
        else if (state_q == FSGC_LOW)
            level_d = ctrl_q[`FSGC_BIT_INIT];
        else
            // (R8) idle rests at starting level
            level_d = ctrl_q[`FSGC_BIT_INIT];
    end

    // Register the output so it comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            camera_sync_pulse <= 1'b0;
        else
            camera_sync_pulse <= level_d;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Registered read mux, valid with pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (req.sel && req.enable && !pready && !req.write)
        begin
            unique case (req.addr)
                // (R5) one-shot bit reads as zero
                `FSGC_ADDR_CTRL: prdata <= {24'h000000, ctrl_q};
                `FSGC_ADDR_HIGH_HI: prdata <= {24'h000000, high_hi_q};
                `FSGC_ADDR_HIGH_LO: prdata <= {24'h000000, high_lo_q};
                `FSGC_ADDR_LOW_HI: prdata <= {24'h000000, low_hi_q};
                `FSGC_ADDR_LOW_LO: prdata <= {24'h000000, low_lo_q};
                // Status: state, running shot, output level
                `FSGC_ADDR_STATUS: prdata <= {28'h0000000, state_q,
                    shot_q, camera_sync_pulse};
                default: prdata <= 32'h00000000;
            endcase
        end
        else
            prdata <= 32'h00000000;
    end

endmodule : fsgc_top

/* tb/fsgc_cam_model.sv */
// Receiving camera: measures the width of every sync level run
`timescale 1ns/1ns
module fsgc_cam_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sync_in,
    output logic [31:0] rise_cnt_q,
    output logic [31:0] hi_len_q,
    output logic [31:0] lo_len_q
);
    logic prev_q; // Level seen last cycle
    logic [31:0] run_q; // Cycles the previous level has stood
    // Record run length on each change; a camera sees only edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q <= 1'b0;
            run_q <= 32'h1;
            rise_cnt_q <= 32'h0;
            hi_len_q <= 32'h0;
            lo_len_q <= 32'h0;
        end
        else if (sync_in == prev_q)
            run_q <= run_q + 32'h1;
        else
        begin
            // Level changed: close the run of the old level
            if (prev_q)
                hi_len_q <= run_q;
            else
                lo_len_q <= run_q;
            if (sync_in)
                rise_cnt_q <= rise_cnt_q + 32'h1;
            prev_q <= sync_in;
            run_q <= 32'h1;
        end
    end
endmodule : fsgc_cam_model

/* tb/fsgc_chk.sv */
// Concurrent checks on the sync generator's APB port
`timescale 1ns/1ns
`include "fsgc_defs.svh"
module fsgc_chk
    import fsgc_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int PINS = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PORTS-1:0] port_frame_tick,
    input wire logic ref_tick,
    input wire logic [PINS-1:0] ext_sync_pin,
    input wire logic camera_sync_pulse
);
    // ------------------------------------------------------------------
    // Bus answer shape
    // ------------------------------------------------------------------
    // All checks share the bus clock; reset mutes them
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Answer comes one cycle into the access phase
    answer_time_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready && psel)
        else $error("pslverr outside an answer");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    shot_reads_zero_a: assert property (pready && !pwrite &&
        paddr == `FSGC_ADDR_CTRL |-> !prdata[`FSGC_BIT_ONESHOT])
        else $error("one-shot bit read back as one");
    // Refused places answer with an error and no data
    unmapped_err_a: assert property (pready &&
        !(paddr inside {[8'h18:8'h1c], 8'h20}) |-> pslverr && prdata == 0)
        else $error("unmapped address not refused");
    mapped_ok_a: assert property (pready &&
        (paddr inside {[8'h18:8'h1c], 8'h20}) |-> !pslverr)
        else $error("mapped address refused");
endmodule : fsgc_chk

/* tb/tb_frame_sync_generator_control.sv */
// Self-checking bench for the camera sync generator
`timescale 1ns/1ns
`include "fsgc_defs.svh"
module tb_frame_sync_generator_control
    import fsgc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, ext_sync_pin;
    logic [31:0] pwdata, prdata, rise_cnt, hi_len, lo_len, r0, q;
    logic [3:0] port_frame_tick;
    logic ref_tick, camera_sync_pulse, e;
    int errors, checks;
    fsgc_top fsgc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_frame_tick(port_frame_tick),
        .ref_tick(ref_tick), .ext_sync_pin(ext_sync_pin),
        .camera_sync_pulse(camera_sync_pulse));
    fsgc_cam_model fsgc_cam_model_i (.pclk(pclk), .presetn(presetn),
        .sync_in(camera_sync_pulse), .rise_cnt_q(rise_cnt),
        .hi_len_q(hi_len), .lo_len_q(lo_len));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rq, output logic re);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic re;
        apb(1'b1, a, d, rq, re);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] rq;
        logic re;
        apb(1'b0, a, 32'h0, rq, re);
        chk(rq, x);
    endtask : rd
    // Fire one shot and measure the active phase width
    task automatic shot(input logic [7:0] c, input int w, input logic lo);
        r0 = rise_cnt;
        wr(`FSGC_ADDR_CTRL, {24'h0, c});
        repeat (60) @(posedge pclk);
        chk(rise_cnt - r0, 32'h1);
        chk(lo ? lo_len : hi_len, w);
        chk({31'h0, camera_sync_pulse}, {31'h0, lo});
    endtask : shot
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------------
    // Clock, reset, watchdog
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Tests need about 2200 cycles; give ample margin
    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {port_frame_tick, ref_tick, ext_sync_pin} = '0;
        errors = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, byte storage and refused address
        for (int i = 0; i < 5; i++)
            rd(8'h18 + 8'(i), 32'h0);
        for (int i = 1; i < 5; i++)
        begin
            wr(8'h18 + 8'(i), 32'hffffff00 | 32'(8'h11 * i));
            rd(8'h18 + 8'(i), 32'(8'h11 * i));
        end
        wr(`FSGC_ADDR_CTRL, 32'hf6);
        rd(`FSGC_ADDR_CTRL, 32'hf6);
        apb(1'b0, 8'h30, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
        // Each internal time base; len 1 gives two cycles
        wr(8'h19, 32'h0);
        wr(8'h1a, 32'h1);
        wr(`FSGC_ADDR_CTRL, 32'h40);
        r0 = rise_cnt;
        wr(`FSGC_ADDR_CTRL, 32'h40);
        repeat (10) @(posedge pclk);
        chk(rise_cnt - r0, 32'h0);
        for (int m = 0; m < 8; m++)
        begin
            port_frame_tick <= (m < 4) ? 4'(1 << m) : 4'h0;
            ref_tick <= (m >= 4);
            shot({4'(m), 4'h8}, 2, 1'b0);
        end
        rd(`FSGC_ADDR_CTRL, 32'h70);
        // Initial level one: active phase is low
        wr(`FSGC_ADDR_CTRL, 32'h44);
        repeat (10) @(posedge pclk);
        shot(8'h4c, 2, 1'b1);
        $display("test one-shot done");
        // External pins pass straight through
        for (int m = 8; m < 16; m++)
        begin
            wr(`FSGC_ADDR_CTRL, {24'h0, 4'(m), 4'h0});
            ext_sync_pin <= 8'(1 << (m - 8));
            repeat (4) @(posedge pclk);
            chk({31'h0, camera_sync_pulse}, 32'h1);
            ext_sync_pin <= ~8'(1 << (m - 8));
            repeat (4) @(posedge pclk);
            chk({31'h0, camera_sync_pulse}, 32'h0);
        end
        ext_sync_pin <= 8'h0;
        $display("test external done");
        // Periodic, separate lengths, upper byte in use
        wr(8'h1a, 32'h2);
        wr(8'h1b, 32'h1);
        wr(8'h1c, 32'h0);
        wr(`FSGC_ADDR_CTRL, 32'h41);
        repeat (700) @(posedge pclk);
        chk(hi_len, 32'd3);
        chk(lo_len, 32'd257);
        // Status in the long low phase: state low, no shot, level 0
        rd(`FSGC_ADDR_STATUS, 32'hc);
        // Symmetric 24-bit length; high upper byte ignored.
        // Style goes first: a low phase cut short by the byte
        // writes must not start a long separate-style high phase
        wr(`FSGC_ADDR_CTRL, 32'h43);
        wr(8'h19, 32'hff);
        wr(8'h1a, 32'h0);
        wr(8'h1b, 32'h0);
        wr(8'h1c, 32'h4);
        repeat (600) @(posedge pclk);
        chk(hi_len, 32'd5);
        chk(lo_len, 32'd5);
        // Disable: waveform stops at initial level
        wr(`FSGC_ADDR_CTRL, 32'h42);
        repeat (30) @(posedge pclk);
        r0 = rise_cnt;
        repeat (40) @(posedge pclk);
        chk(rise_cnt - r0, 32'h0);
        chk({31'h0, camera_sync_pulse}, 32'h0);
        $display("test periodic done");
        wrap_up();
    end
endmodule : tb_frame_sync_generator_control
bind fsgc_top fsgc_chk #(.PORTS(PORTS), .PINS(PINS)) fsgc_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_frame_tick(port_frame_tick),
    .ref_tick(ref_tick), .ext_sync_pin(ext_sync_pin),
    .camera_sync_pulse(camera_sync_pulse));
